// ### nco_pkg.sv
package nco_pkg;
  localparam int ACC_W        = 20;
  localparam int BYTE_W       = 8;
  localparam int UPPER_W      = 4;
  localparam int WSEL_W       = 3;
  localparam int CSEL_W       = 4;
  localparam int NUM_SRC      = 16;
  localparam int PW_CNT_W     = 8;
  localparam int LOAD_EDGES   = 2;
  localparam logic [CSEL_W-1:0] CSEL_FAST_OSC = 4'h1;
  localparam logic [BYTE_W-1:0]  RESET_BYTE  = 8'h00;
  localparam logic [ACC_W-1:0]   RESET_ACC   = 20'h00000;
  typedef enum logic [1:0] {LOAD_IDLE, LOAD_WAIT1, LOAD_WAIT2} load_state_t;
endpackage : nco_pkg

// ### edge_detect.sv
`timescale 1ns/100ps
module edge_detect (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic level_in,
  output logic      rise
);
  logic prev_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 1'b0;
    end else if (clk_en) begin
      prev_reg <= level_in;
    end
  end
  assign rise = clk_en & level_in & ~prev_reg;
endmodule : edge_detect

// ### numeric_phase_oscillator.sv
`timescale 1ns/100ps
// Function
// [R01] 20-bit accumulator, three byte registers
// [R02] each input edge adds buffered increment
// [R03] adder carry is raw overflow
// [R04] increment held in three byte registers
// [R05] low write loads buffer, second edge
// [R06] software writes upper/high before low
// [R07] disabled: buffer loads right after write
// [R08] reads return registers, not buffers
// [R09] fixed duty: toggle on overflow
// [R10] mode bit selects fixed or pulse
// [R11] pulse: assert after overflow, timed width
// [R12] pulse longer than interval: no toggle
// [R13] polarity inverts final output
// [R14] polarity change raises interrupt
// [R15] overflow sets interrupt flag
// [R16] request needs all four enables
// [R17] flag holds until software clears
// [R18] reset clears every register
// [R19] runs on input clock during sleep
// [R20] fast oscillator kept on in sleep
// [R21] clock source select picks input clock
// [R22] final output routed to peripherals
// [R23] width is two to field periods
// [R24] status bit shows output level
// [R25] runs only while enabled
// [R26] no accumulator writes while running; the code accepts them, and a write skips that tick's add
// [R27] accumulator wraps modulo two to twenty
module numeric_phase_oscillator
  import nco_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  input  wire logic [nco_pkg::NUM_SRC-1:0] clock_sources,
  input  wire logic                        sleep_mode,
  input  wire logic [nco_pkg::BYTE_W-1:0]  wr_data,
  input  wire logic                        wr_inc_low,
  input  wire logic                        wr_inc_high,
  input  wire logic                        wr_inc_upper,
  input  wire logic                        wr_acc_low,
  input  wire logic                        wr_acc_high,
  input  wire logic                        wr_acc_upper,
  input  wire logic                        module_enable,
  input  wire logic                        pulse_mode_select,
  input  wire logic                        output_polarity,
  input  wire logic [nco_pkg::WSEL_W-1:0]  pulse_width_select,
  input  wire logic [nco_pkg::CSEL_W-1:0]  input_clock_select,
  input  wire logic                        overflow_irq_enable,
  input  wire logic                        periph_irq_enable,
  input  wire logic                        global_irq_enable,
  input  wire logic                        irq_flag_clear,
  output logic [nco_pkg::BYTE_W-1:0]       increment_low_byte,
  output logic [nco_pkg::BYTE_W-1:0]       increment_high_byte,
  output logic [nco_pkg::BYTE_W-1:0]       increment_upper_byte,
  output logic [nco_pkg::BYTE_W-1:0]       accumulator_low_byte,
  output logic [nco_pkg::BYTE_W-1:0]       accumulator_high_byte,
  output logic [nco_pkg::BYTE_W-1:0]       accumulator_upper_byte,
  output logic                             raw_overflow,
  output logic                             oscillator_output,
  output logic                             output_status,
  output logic                             overflow_irq_flag,
  output logic                             irq_request,
  output logic                             keep_fast_osc
);
  import nco_pkg::*;

  logic [BYTE_W-1:0]  inc_low_reg;
  logic [BYTE_W-1:0]  inc_high_reg;
  logic [UPPER_W-1:0] inc_upper_reg;
  logic [ACC_W-1:0]   inc_buf_reg;
  logic [ACC_W-1:0]   acc_reg;
  logic [ACC_W:0]     sum;
  logic               accumulator_clock;
  logic               nco_tick;
  logic               load_pending;
  load_state_t        load_state_reg;
  logic               duty_reg;
  logic               pulse_reg;
  logic [PW_CNT_W-1:0] pw_cnt_reg;
  logic [PW_CNT_W:0]  pw_len;
  logic               polarity_prev_reg;
  logic               out_next;
  logic               out_reg;

  // input clock sampled as a level; a rising edge becomes a one-cycle tick
  assign accumulator_clock = clock_sources[input_clock_select];       // [R21]
  edge_detect u_edge (
    .clock    (clock),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .level_in (accumulator_clock),
    .rise     (nco_tick)
  );

  // sleep_mode is deliberately ignored: logic never depends on the cpu clock
  assign keep_fast_osc = module_enable && (input_clock_select == CSEL_FAST_OSC); // [R20] [R19]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inc_low_reg   <= RESET_BYTE;                                      // [R18]
      inc_high_reg  <= RESET_BYTE;
      inc_upper_reg <= '0;
    end else if (clk_en) begin
      if (wr_inc_low) begin
        inc_low_reg <= wr_data;                                         // [R04]
      end
      if (wr_inc_high) begin
        inc_high_reg <= wr_data;
      end
      if (wr_inc_upper) begin
        inc_upper_reg <= wr_data[UPPER_W-1:0];
      end
    end
  end

  // [R08] reads come from the byte registers only
  assign increment_low_byte   = inc_low_reg;
  assign increment_high_byte  = inc_high_reg;
  assign increment_upper_byte = {{(BYTE_W-UPPER_W){1'b0}}, inc_upper_reg};

  // enabled: wait for the second input edge after the low-byte write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      load_state_reg <= LOAD_IDLE;
    end else if (clk_en) begin
      if (!module_enable) begin
        load_state_reg <= LOAD_IDLE;
      end else if (wr_inc_low) begin
        load_state_reg <= LOAD_WAIT1;                                   // [R05]
      end else begin
        case (load_state_reg)
          LOAD_IDLE:  load_state_reg <= LOAD_IDLE;
          LOAD_WAIT1: if (nco_tick) load_state_reg <= LOAD_WAIT2;
          LOAD_WAIT2: if (nco_tick) load_state_reg <= LOAD_IDLE;
          default:    load_state_reg <= LOAD_IDLE;
        endcase
      end
    end
  end
  assign load_pending = (load_state_reg == LOAD_WAIT2) && nco_tick;

  // the buffer copies registers as they stood before this cycle's write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inc_buf_reg <= RESET_ACC;
    end else if (clk_en) begin
      if (!module_enable) begin
        inc_buf_reg <= {inc_upper_reg, inc_high_reg, inc_low_reg};      // [R07]
      end else if (load_pending) begin
        inc_buf_reg <= {inc_upper_reg, inc_high_reg, inc_low_reg};      // [R05]
      end
    end
  end

  assign sum = {1'b0, acc_reg} + {1'b0, inc_buf_reg};                   // [R02]
  assign raw_overflow = module_enable && nco_tick && sum[ACC_W];        // [R03] [R25]

  // writes while running are honoured and take priority over that tick's add
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= RESET_ACC;
    end else if (clk_en) begin
      if (wr_acc_low) begin
        acc_reg[7:0] <= wr_data;                                        // [R01] [R26]
      end else if (wr_acc_high) begin
        acc_reg[15:8] <= wr_data;
      end else if (wr_acc_upper) begin
        acc_reg[ACC_W-1:16] <= wr_data[UPPER_W-1:0];
      end else if (module_enable && nco_tick) begin
        acc_reg <= sum[ACC_W-1:0];                                      // [R02] [R27]
      end
    end
  end
  assign accumulator_low_byte   = acc_reg[7:0];
  assign accumulator_high_byte  = acc_reg[15:8];
  assign accumulator_upper_byte = {{(BYTE_W-UPPER_W){1'b0}}, acc_reg[ACC_W-1:16]};

  assign pw_len = (PW_CNT_W+1)'(1) << pulse_width_select;               // [R23]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      duty_reg <= 1'b0;
    end else if (clk_en) begin
      if (!module_enable) begin
        duty_reg <= 1'b0;                                               // [R25]
      end else if (raw_overflow) begin
        duty_reg <= ~duty_reg;                                          // [R09]
      end
    end
  end

  // an overflow inside a running pulse restarts it, so the output never drops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pulse_reg  <= 1'b0;
      pw_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!module_enable) begin
        pulse_reg  <= 1'b0;
        pw_cnt_reg <= '0;
      end else if (raw_overflow) begin
        pulse_reg  <= 1'b1;                                             // [R11] [R12]
        pw_cnt_reg <= PW_CNT_W'(pw_len - 1'b1);
      end else if (pulse_reg && nco_tick) begin
        if (pw_cnt_reg == '0) begin
          pulse_reg <= 1'b0;                                            // [R11]
        end else begin
          pw_cnt_reg <= pw_cnt_reg - 1'b1;
        end
      end
    end
  end

  always_comb begin
    out_next = pulse_mode_select ? pulse_reg : duty_reg;                // [R10]
    out_next = out_next ^ output_polarity;                              // [R13]
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_reg           <= 1'b0;
      polarity_prev_reg <= 1'b0;
    end else if (clk_en) begin
      out_reg           <= out_next;
      polarity_prev_reg <= output_polarity;
    end
  end
  assign oscillator_output = out_reg;                                   // [R22]
  assign output_status     = out_reg;                                   // [R24]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq_flag <= 1'b0;
    end else if (clk_en) begin
      if (raw_overflow || (module_enable && overflow_irq_enable
                           && output_polarity != polarity_prev_reg)) begin
        overflow_irq_flag <= 1'b1;                                      // [R15] [R14] [R17]
      end else if (irq_flag_clear) begin
        overflow_irq_flag <= 1'b0;                                      // [R17]
      end
    end
  end

  assign irq_request = overflow_irq_flag && module_enable && overflow_irq_enable
                       && periph_irq_enable && global_irq_enable;       // [R16]

  property p_ovf_sets_flag;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && raw_overflow) |=> overflow_irq_flag;
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag) else $error("flag not set"); // [R15]

  property p_flag_holds;
    @(posedge clock) disable iff (!arst_n)
      (overflow_irq_flag && !irq_flag_clear) |=> overflow_irq_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped"); // [R17]

  property p_irq_gate;
    @(posedge clock) disable iff (!arst_n)
      irq_request |-> (module_enable && overflow_irq_enable && periph_irq_enable
                       && global_irq_enable && overflow_irq_flag);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated"); // [R16]

  property p_duty_toggle;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && raw_overflow) |=> (duty_reg != $past(duty_reg));
  endproperty
  a_duty_toggle: assert property (p_duty_toggle) else $error("no toggle"); // [R09]

  property p_wrap;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && module_enable && nco_tick && !wr_acc_low && !wr_acc_high
       && !wr_acc_upper) |=> (acc_reg == ACC_W'($past(sum)));
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad sum"); // [R27]

  property p_idle_stop;
    @(posedge clock) disable iff (!arst_n)
      !module_enable |-> !raw_overflow;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("overflow while off"); // [R25]

  sequence s_arm;
    clk_en && module_enable && wr_inc_low;
  endsequence
  property p_no_early_load;
    @(posedge clock) disable iff (!arst_n)
      s_arm ##1 (clk_en && module_enable && !nco_tick && !wr_inc_low
                 && !wr_inc_high && !wr_inc_upper) |=> $stable(inc_buf_reg);
  endproperty
  a_no_early_load: assert property (p_no_early_load) else $error("early load"); // [R05]

  property p_disabled_load;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && !module_enable) |=> (inc_buf_reg == {$past(inc_upper_reg), $past(inc_high_reg),
                                                      $past(inc_low_reg)});
  endproperty
  a_disabled_load: assert property (p_disabled_load) else $error("no load"); // [R07]

  property p_polarity;
    @(posedge clock) disable iff (!arst_n)
      clk_en |=> (out_reg == ($past(pulse_mode_select) ? $past(pulse_reg) : $past(duty_reg))
                  ^ $past(output_polarity));
  endproperty
  a_polarity: assert property (p_polarity) else $error("bad output"); // [R13]
endmodule : numeric_phase_oscillator

// ### nco_peer.sv
`timescale 1ns/100ps
module nco_peer (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        out_level,
  input  wire logic        count_clear,
  output logic [15:0]      clock_sources,
  output logic [15:0]      rise_count,
  output logic [15:0]      high_count
);
  logic [3:0] div_reg;
  logic       last_reg;
  // index k runs at the rate of divider bit k mod 4, so a select with other low two bits changes the tick rate
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      clock_sources[k] = div_reg[k % 4];
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end
  // receiving peripheral: counts edges and active time of the routed output
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_reg   <= 1'b0;
      rise_count <= 16'h0000;
      high_count <= 16'h0000;
    end else if (count_clear) begin
      last_reg   <= out_level;
      rise_count <= 16'h0000;
      high_count <= 16'h0000;
    end else begin
      last_reg   <= out_level;
      rise_count <= rise_count + 16'((out_level === 1'b1) && !last_reg);
      high_count <= high_count + 16'(out_level === 1'b1);
    end
  end
endmodule : nco_peer

// ### numeric_phase_oscillator_tb.sv
`timescale 1ns/100ps
module numeric_phase_oscillator_tb;
  import nco_pkg::*;
  localparam int WIN = 400;
  logic        clock, arst_n, clk_en, sleep_mode, count_clear, irq_flag_clear;
  logic [7:0]  wr_data;
  logic [5:0]  wr_vec;
  logic        module_enable, pulse_mode_select, output_polarity;
  logic [2:0]  pulse_width_select;
  logic [3:0]  input_clock_select;
  logic        overflow_irq_enable, periph_irq_enable, global_irq_enable;
  logic [15:0] clock_sources, rise_count, high_count;
  logic [7:0]  increment_low_byte, increment_high_byte, increment_upper_byte;
  logic [7:0]  accumulator_low_byte, accumulator_high_byte, accumulator_upper_byte;
  logic        raw_overflow, oscillator_output, output_status;
  logic        overflow_irq_flag, irq_request, keep_fast_osc;
  wire  [23:0] acc_all = {accumulator_upper_byte, accumulator_high_byte, accumulator_low_byte};
  int          n_fail, num_checks, ovf_n;

  numeric_phase_oscillator u_numeric_phase_oscillator (
    .clock, .arst_n, .clk_en, .clock_sources, .sleep_mode, .wr_data,
    .wr_inc_low(wr_vec[0]), .wr_inc_high(wr_vec[1]), .wr_inc_upper(wr_vec[2]),
    .wr_acc_low(wr_vec[3]), .wr_acc_high(wr_vec[4]), .wr_acc_upper(wr_vec[5]),
    .module_enable, .pulse_mode_select, .output_polarity, .pulse_width_select,
    .input_clock_select, .overflow_irq_enable, .periph_irq_enable, .global_irq_enable,
    .irq_flag_clear, .increment_low_byte, .increment_high_byte, .increment_upper_byte,
    .accumulator_low_byte, .accumulator_high_byte, .accumulator_upper_byte,
    .raw_overflow, .oscillator_output, .output_status, .overflow_irq_flag,
    .irq_request, .keep_fast_osc
  );
  nco_peer u_nco_peer (
    .clock, .arst_n, .out_level(oscillator_output), .count_clear, .clock_sources,
    .rise_count, .high_count
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // overflow pulse is combinational, so sample it away from the launching edge
  always @(negedge clock) begin
    if (count_clear === 1'b1) ovf_n = 0;
    else if (raw_overflow === 1'b1) ovf_n++;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic rng(input string nm, input int lo, input int hi, input logic [31:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : rng
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clock);
    wr_data <= d;
    wr_vec  <= 6'h01 << k;
    @(posedge clock);
    wr_vec  <= 6'h00;
  endtask : wr
  task automatic set_inc(input logic [19:0] v);
    wr(2, {4'h0, v[19:16]});
    wr(1, v[15:8]);
    wr(0, v[7:0]);
  endtask : set_inc
  task automatic cfg(input logic en, pm, inv, input logic [2:0] wsel, input logic [3:0] csel);
    @(posedge clock);
    module_enable      <= en;
    pulse_mode_select  <= pm;
    output_polarity    <= inv;
    pulse_width_select <= wsel;
    input_clock_select <= csel;
  endtask : cfg
  task automatic meas(input int n);
    @(posedge clock);
    count_clear <= 1'b1;
    @(posedge clock);
    count_clear <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : meas
  task automatic clr;
    @(posedge clock);
    irq_flag_clear <= 1'b1;
    @(posedge clock);
    irq_flag_clear <= 1'b0;
    @(posedge clock);
  endtask : clr

  task automatic t_regs;
    chk("reset", 0, {acc_all, overflow_irq_flag, oscillator_output});
    chk("inc reset", 0, {increment_upper_byte, increment_high_byte, increment_low_byte});
    set_inc(20'h5C3A1);
    @(posedge clock);
    chk("inc bytes", 24'h05C3A1, {increment_upper_byte, increment_high_byte, increment_low_byte});
    wr(5, 8'h07); // acc written only while disabled
    wr(4, 8'h34);
    wr(3, 8'h12);
    @(posedge clock);
    chk("acc bytes", 24'h073412, acc_all);
    for (int k = 3; k < 6; k++) wr(k, 8'h00);
    set_inc(20'h80000); // loads at once while disabled
    repeat (40) @(posedge clock);
    chk("disabled acc", 0, acc_all);
    chk("disabled flag", 0, overflow_irq_flag);
    chk("fast osc off", 0, keep_fast_osc);
  endtask : t_regs
  task automatic t_duty;
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 4'h0);
    meas(WIN);
    rng("overflows", WIN / 4 - 1, WIN / 4 + 1, ovf_n);
    rng("duty rises", WIN / 8 - 1, WIN / 8 + 1, rise_count);
    rng("duty high", WIN / 2 - 8, WIN / 2 + 8, high_count);
    chk("irq all set", 2'b11, {overflow_irq_flag, irq_request});
    global_irq_enable <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    chk("irq no global", 0, irq_request);
    global_irq_enable <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 3'h0, 4'h0);
    repeat (8) @(posedge clock);
    chk("irq disabled", 2'b10, {overflow_irq_flag, irq_request});
    chk("acc wrap", 0, acc_all & 24'h77FFFF);
  endtask : t_duty
  task automatic t_select;
    sleep_mode <= 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 3'h0, CSEL_FAST_OSC);
    meas(WIN);
    rng("slow rises", WIN / 16 - 1, WIN / 16 + 1, rise_count);
    chk("fast osc kept", 1, keep_fast_osc);
    sleep_mode <= 1'b0;
  endtask : t_select
  task automatic t_pulse;
    cfg(1'b1, 1'b1, 1'b0, 3'h0, 4'h0);
    meas(WIN);
    rng("pulse rises", WIN / 4 - 1, WIN / 4 + 1, rise_count);
    cfg(1'b1, 1'b1, 1'b0, 3'h2, 4'h0);
    meas(WIN);
    chk("wide pulse level", 1, oscillator_output);
    rng("wide pulse high", WIN - 10, WIN, high_count);
    rng("wide pulse rises", 0, 1, rise_count);
    chk("status high", 1, output_status);
    cfg(1'b1, 1'b1, 1'b1, 3'h2, 4'h0);
    repeat (6) @(posedge clock);
    chk("inverted", 0, {oscillator_output, output_status});
    cfg(1'b0, 1'b0, 1'b1, 3'h0, 4'h0);
    repeat (6) @(posedge clock);
    chk("idle polarity", 1, oscillator_output);
  endtask : t_pulse
  task automatic t_pol_irq;
    for (int k = 3; k < 6; k++) wr(k, 8'h00);
    set_inc(20'h00000);
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 4'h0);
    clr();
    repeat (20) @(posedge clock);
    chk("no overflow", 0, overflow_irq_flag);
    cfg(1'b1, 1'b0, 1'b1, 3'h0, 4'h0);
    repeat (4) @(posedge clock);
    chk("polarity irq", 1, overflow_irq_flag);
    repeat (10) @(posedge clock);
    chk("flag held", 1, overflow_irq_flag);
    clr();
    chk("flag cleared", 0, overflow_irq_flag);
    set_inc(20'h80000);
    // an early load would already have moved the accumulator by now
    repeat (4) @(posedge clock);
    chk("load waits", 0, acc_all);
    repeat (20) @(posedge clock);
    chk("load done", 1, overflow_irq_flag);
  endtask : t_pol_irq

  initial begin
    arst_n = 1'b0;
    {clk_en, overflow_irq_enable, periph_irq_enable, global_irq_enable} = 4'hF;
    {sleep_mode, count_clear, irq_flag_clear, module_enable} = 4'h0;
    {pulse_mode_select, output_polarity, pulse_width_select} = 5'h00;
    input_clock_select = 4'h0;
    wr_data = 8'h00;
    wr_vec = 6'h00;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_duty();
    t_select();
    t_pulse();
    t_pol_irq();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("Error watchdog expected done seen timeout");
    end_sim();
  end
endmodule : numeric_phase_oscillator_tb
